// ---- rtl/pcc_map.vh ----
// register map and constants of the pixel correction control block
// How it works
// - control offset 0x00, bit 0 enables core
// - status offset 0x08, bit 7 means healthy
// - software reset acts at once, tearing allowed
// - soft reset: thresholds reset, outputs held idle
// - after soft reset, resync then resume
// - update on: thresholds load each vblank rise
// - update off: writes stored, not used
// - update control needs core enable set
// - every register 32 bits, writes honour byte strobes
// - register at base address plus offset
// - axi4-lite bus, behaviour independent of it
// - one active-high reset for whole core
// - one clock for bus and video
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define PCC_ADDR_W        8
`define PCC_OFF_CONTROL   8'h00
`define PCC_OFF_STATUS    8'h08
`define PCC_OFF_TEMPORAL  8'h0C
`define PCC_OFF_SPATIAL   8'h10
`define PCC_OFF_AGE       8'h14

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PCC_CTL_ENABLE    0
`define PCC_CTL_UPDATE    1
`define PCC_CTL_SWRESET   2
`define PCC_STA_SYNCED    0
`define PCC_STA_OK        7

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define PCC_CONTROL_RST   32'h00000000
`define PCC_TEMPORAL_RST  32'h00000002
`define PCC_SPATIAL_RST   32'h0000199A
`define PCC_AGE_RST       32'h000004B0
`define PCC_DATA_W        8
`define PCC_RESP_OKAY     2'h0
`define PCC_RESP_SLVERR   2'h2

`endif

// ---- rtl/pcc_vid_gate.v ----
// video timing gate: holds outputs idle and resyncs to vblank
`timescale 1ns/100ps
`include "pcc_map.vh"

module pcc_vid_gate (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   hold_in,
  input  wire                   vblank_in,
  input  wire                   hblank_in,
  input  wire                   active_video_in,
  input  wire [`PCC_DATA_W-1:0] video_data_in,
  output reg                    vblank_out,
  output reg                    hblank_out,
  output reg                    active_video_out,
  output reg  [`PCC_DATA_W-1:0] video_data_out,
  output reg                    synced_out,
  output wire                   vblank_rise_out
);

  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg       vblank_d_r;

  assign vblank_rise_out = vblank_in & ~vblank_d_r;

  // ----------------------------------------------------------------
  // resync state
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_WAIT: if (vblank_rise_out) state_nxt = ST_RUN;
      ST_RUN:  state_nxt = ST_RUN;
      default: state_nxt = ST_WAIT;
    endcase
    if (hold_in) state_nxt = ST_WAIT;
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state_r          <= ST_WAIT;
      vblank_d_r       <= 1'b0;
      vblank_out       <= 1'b0;
      hblank_out       <= 1'b0;
      active_video_out <= 1'b0;
      video_data_out   <= {`PCC_DATA_W{1'b0}};
      synced_out       <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      vblank_d_r <= vblank_in;
      synced_out <= (state_nxt == ST_RUN);
      // outputs stay at reset values until a frame boundary is seen
      if (hold_in || state_nxt != ST_RUN) begin
        vblank_out       <= 1'b0;
        hblank_out       <= 1'b0;
        active_video_out <= 1'b0;
        video_data_out   <= {`PCC_DATA_W{1'b0}};
      end else begin
        vblank_out       <= vblank_in;
        hblank_out       <= hblank_in;
        active_video_out <= active_video_in;
        video_data_out   <= video_data_in;
      end
    end
  end

endmodule // pcc_vid_gate

// ---- rtl/pcc_ctrl_regs.v ----
// axi4-lite register bank and threshold update gate
`timescale 1ns/100ps
`include "pcc_map.vh"

module pcc_ctrl_regs (
  input  wire                   clk_in,
  input  wire                   rst_in,
  // axi4-lite slave
  input  wire [`PCC_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire                   s_axi_awvalid_in,
  output reg                    s_axi_awready_out,
  input  wire [31:0]            s_axi_wdata_in,
  input  wire [3:0]             s_axi_wstrb_in,
  input  wire                   s_axi_wvalid_in,
  output reg                    s_axi_wready_out,
  output reg  [1:0]             s_axi_bresp_out,
  output reg                    s_axi_bvalid_out,
  input  wire                   s_axi_bready_in,
  input  wire [`PCC_ADDR_W-1:0] s_axi_araddr_in,
  input  wire                   s_axi_arvalid_in,
  output reg                    s_axi_arready_out,
  output reg  [31:0]            s_axi_rdata_out,
  output reg  [1:0]             s_axi_rresp_out,
  output reg                    s_axi_rvalid_out,
  input  wire                   s_axi_rready_in,
  // video
  input  wire                   vblank_in,
  input  wire                   hblank_in,
  input  wire                   active_video_in,
  input  wire [`PCC_DATA_W-1:0] video_data_in,
  output wire                   vblank_out,
  output wire                   hblank_out,
  output wire                   active_video_out,
  output wire [`PCC_DATA_W-1:0] video_data_out,
  // thresholds in use by the datapath
  output reg  [31:0]            thresh_temporal_out,
  output reg  [31:0]            thresh_spatial_out,
  output reg  [31:0]            thresh_age_out
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // unmapped offsets answer with an error and store nothing
  function mapped;
    input [`PCC_ADDR_W-1:0] a;
    begin
      mapped = (a == `PCC_OFF_CONTROL) || (a == `PCC_OFF_STATUS) ||
               (a == `PCC_OFF_TEMPORAL) || (a == `PCC_OFF_SPATIAL) ||
               (a == `PCC_OFF_AGE);
    end
  endfunction

  // byte-lane merge of a 32-bit write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i]) merge[i*8 +: 8] = din[i*8 +: 8];
    end
  endfunction

  reg  [31:0]            control_r;
  reg  [31:0]            temporal_r;
  reg  [31:0]            spatial_r;
  reg  [31:0]            age_r;
  reg  [31:0]            ctl_nxt;
  wire                   synced;
  wire                   vblank_rise;
  wire                   wr_go;
  wire                   rd_go;
  wire                   core_en;
  wire                   sw_reset;
  wire                   upd_live;

  assign core_en  = control_r[`PCC_CTL_ENABLE];
  assign sw_reset = control_r[`PCC_CTL_SWRESET];
  // update is only honoured while the core is enabled
  assign upd_live = core_en & control_r[`PCC_CTL_UPDATE];

  // address and data are taken only together, one write in flight
  assign wr_go = s_axi_awready_out & s_axi_awvalid_in &
                 s_axi_wready_out & s_axi_wvalid_in;
  assign rd_go = s_axi_arready_out & s_axi_arvalid_in;

  // ----------------------------------------------------------------
  // control word: the update bit moves only while enabled or on the enabling write
  // ----------------------------------------------------------------
  always @* begin
    ctl_nxt = merge(control_r, s_axi_wdata_in, s_axi_wstrb_in);
    // bits above the soft reset flag are reserved and read zero
    ctl_nxt[31:3] = 29'h0;
    // a disabled core keeps its update bit, so writes that leave the core
    // disabled never start or stop threshold reloads
    if (!core_en && !ctl_nxt[`PCC_CTL_ENABLE])
      ctl_nxt[`PCC_CTL_UPDATE] = control_r[`PCC_CTL_UPDATE];
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `PCC_RESP_OKAY;
      control_r         <= `PCC_CONTROL_RST;
      temporal_r        <= `PCC_TEMPORAL_RST;
      spatial_r         <= `PCC_SPATIAL_RST;
      age_r             <= `PCC_AGE_RST;
    end else begin
      // a new write is offered only once the previous answer is taken
      if (wr_go) begin
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out  <= 1'b0;
        s_axi_bvalid_out  <= 1'b1;
        s_axi_bresp_out   <= mapped(s_axi_awaddr_in) ?
                             `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
      end else if (s_axi_awvalid_in && s_axi_wvalid_in &&
                   !s_axi_awready_out && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
      end
      // a control write takes effect on the very next edge
      if (wr_go && s_axi_awaddr_in == `PCC_OFF_CONTROL)
        control_r <= ctl_nxt;
      // thresholds are latched regardless of the update bit
      // thresholds written during soft reset are lost
      if (sw_reset) begin
        temporal_r <= `PCC_TEMPORAL_RST;
        spatial_r  <= `PCC_SPATIAL_RST;
        age_r      <= `PCC_AGE_RST;
      end else if (wr_go) begin
        if (s_axi_awaddr_in == `PCC_OFF_TEMPORAL)
          temporal_r <= merge(temporal_r, s_axi_wdata_in, s_axi_wstrb_in);
        if (s_axi_awaddr_in == `PCC_OFF_SPATIAL)
          spatial_r <= merge(spatial_r, s_axi_wdata_in, s_axi_wstrb_in);
        if (s_axi_awaddr_in == `PCC_OFF_AGE)
          age_r <= merge(age_r, s_axi_wdata_in, s_axi_wstrb_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `PCC_RESP_OKAY;
    end else begin
      // a new read is offered only once the previous data is taken
      if (rd_go) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= mapped(s_axi_araddr_in) ?
                             `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
        // status is built live from the gate and the control word
        case (s_axi_araddr_in)
          `PCC_OFF_CONTROL:  s_axi_rdata_out <= control_r;
          `PCC_OFF_STATUS:   s_axi_rdata_out <=
            {24'h0, core_en & ~sw_reset & synced, 6'h0,
             synced};
          `PCC_OFF_TEMPORAL: s_axi_rdata_out <= temporal_r;
          `PCC_OFF_SPATIAL:  s_axi_rdata_out <= spatial_r;
          `PCC_OFF_AGE:      s_axi_rdata_out <= age_r;
          default:           s_axi_rdata_out <= 32'h00000000;
        endcase
      end else if (s_axi_arvalid_in && !s_axi_arready_out &&
                   !s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // thresholds in use: reload on every vblank rise while update and core enable are both on
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    // soft reset wins over a reload that falls in the same cycle
    if (rst_in || sw_reset) begin
      thresh_temporal_out <= `PCC_TEMPORAL_RST;
      thresh_spatial_out  <= `PCC_SPATIAL_RST;
      thresh_age_out      <= `PCC_AGE_RST;
    end else if (upd_live && vblank_rise) begin
      thresh_temporal_out <= temporal_r;
      thresh_spatial_out  <= spatial_r;
      thresh_age_out      <= age_r;
    end
  end

  // single clock throughout, so no crossing is needed
  // a disabled core is held like a soft reset and must resync
  // pixels pass unchanged; the correction datapath sits outside
  pcc_vid_gate u_gate (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .hold_in          (sw_reset | ~core_en),
    .vblank_in        (vblank_in),
    .hblank_in        (hblank_in),
    .active_video_in  (active_video_in),
    .video_data_in    (video_data_in),
    .vblank_out       (vblank_out),
    .hblank_out       (hblank_out),
    .active_video_out (active_video_out),
    .video_data_out   (video_data_out),
    .synced_out       (synced),
    .vblank_rise_out  (vblank_rise)
  );

endmodule // pcc_ctrl_regs

// ---- sim/pcc_ctrl_regs_properties.sv ----
// checker on the ports of the register and update block
`timescale 1ns/100ps
module pcc_ctrl_regs_properties (
  input wire        clk_in,
  input wire        rst_in,
  input wire        s_axi_awready_out,
  input wire        s_axi_wready_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in,
  input wire        s_axi_arready_out,
  input wire        s_axi_rvalid_out,
  input wire        s_axi_rready_in,
  input wire        vblank_in,
  input wire        vblank_out,
  input wire [31:0] thresh_temporal_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_pair; s_axi_awready_out |-> s_axi_wready_out; endproperty
  property p_awp; s_axi_awready_out |=> !s_axi_awready_out; endproperty
  property p_bans; $rose(s_axi_bvalid_out) |-> $past(s_axi_awready_out);
  endproperty
  property p_bhold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
  endproperty
  property p_rans; s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  property p_rhold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out;
  endproperty
  property p_rst; $fell(rst_in) |-> thresh_temporal_out == 32'h00000002;
  endproperty
  property p_vb; vblank_out |-> $past(vblank_in); endproperty
  // a load of a new value only follows a sampled 0 then 1 on vblank
  property p_upd; !$stable(thresh_temporal_out) &&
    thresh_temporal_out != 32'h00000002 |->
    $past(vblank_in) && !$past(vblank_in, 2); endproperty
  a_pair: assert property (p_pair)
    else $error("address and data ready apart");
  a_awp: assert property (p_awp)
    else $error("address ready longer than one cycle");
  a_bans: assert property (p_bans)
    else $error("write answer without handshake");
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped early");
  a_rans: assert property (p_rans)
    else $error("read answer late");
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped early");
  a_rst: assert property (p_rst)
    else $error("threshold not at reset value");
  a_vb: assert property (p_vb)
    else $error("vblank out without vblank in");
  a_upd: assert property (p_upd)
    else $error("threshold loaded off a vblank rise");
  c_rd: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_upd: cover property (!$stable(thresh_temporal_out));
endmodule // pcc_ctrl_regs_properties
bind pcc_ctrl_regs pcc_ctrl_regs_properties u_chk (.*);

// ---- sim/pcc_host.sv ----
// host model: axi4-lite master, one access in flight
`timescale 1ns/100ps
module pcc_host (
  input  wire        clk_in,
  output reg  [7:0]  s_axi_awaddr_in,
  output reg         s_axi_awvalid_in,
  input  wire        s_axi_awready_out,
  output reg  [31:0] s_axi_wdata_in,
  output reg  [3:0]  s_axi_wstrb_in,
  output reg         s_axi_wvalid_in,
  input  wire        s_axi_wready_out,
  input  wire [1:0]  s_axi_bresp_out,
  input  wire        s_axi_bvalid_out,
  output reg         s_axi_bready_in,
  output reg  [7:0]  s_axi_araddr_in,
  output reg         s_axi_arvalid_in,
  input  wire        s_axi_arready_out,
  input  wire [31:0] s_axi_rdata_out,
  input  wire [1:0]  s_axi_rresp_out,
  input  wire        s_axi_rvalid_out,
  output reg         s_axi_rready_in
);
  wire [3:0] st = {s_axi_rvalid_out, s_axi_arready_out,
                   s_axi_bvalid_out, s_axi_awready_out};
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in} = 3'h0;
    {s_axi_bready_in, s_axi_rready_in} = 2'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
    s_axi_wstrb_in = 4'hF;
  end
  task wt(input integer i);
    integer n;
    begin
      n = 0;
      while (st[i] !== 1'b1 && n < 40)
        @(posedge clk_in) #1 n = n + 1;
      if (n == 40)
        test_pixel_correction_control_regs.hang;
    end
  endtask
  // address and data travel together; no lone channel is offered
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      {s_axi_awaddr_in, s_axi_wdata_in} = {a, d};
      {s_axi_awvalid_in, s_axi_wvalid_in} = 2'h3;
      wt(0);
      @(posedge clk_in) #1 {s_axi_awvalid_in, s_axi_wvalid_in} = 2'h0;
      {s_axi_awaddr_in, s_axi_wdata_in} = ~{a, d};
      wt(1);
      @(posedge clk_in) #1 s_axi_bready_in = 1'b1;
      r = s_axi_bresp_out;
      @(posedge clk_in) #1 s_axi_bready_in = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr_in = a;
      s_axi_arvalid_in = 1'b1;
      wt(2);
      @(posedge clk_in) #1 s_axi_arvalid_in = 1'b0;
      s_axi_araddr_in = ~a;
      wt(3);
      @(posedge clk_in) #1 s_axi_rready_in = 1'b1;
      {d, r} = {s_axi_rdata_out, s_axi_rresp_out};
      @(posedge clk_in) #1 s_axi_rready_in = 1'b0;
    end
  endtask
endmodule // pcc_host

// ---- sim/test_pixel_correction_control_regs.sv ----
// self-checking bench for the register and update block
`timescale 1ns/100ps
`include "pcc_map.vh"
module test_pixel_correction_control_regs;
  reg         clk_in = 1'b0, rst_in = 1'b1, vblank_in = 1'b0;
  reg         hblank_in = 1'b0, active_video_in = 1'b0, sync = 1'b0;
  reg  [7:0]  video_data_in = 8'h00;
  reg  [9:0]  pix;
  reg  [31:0] sto [0:2], act [0:2], rsv [0:2], d, rnd;
  reg  [2:0]  ctl = 3'h0;
  reg  [1:0]  r;
  integer     err_total = 0, compares = 0, seed = 89801, i, k;
  wire [7:0]  s_axi_awaddr_in, s_axi_araddr_in, video_data_out;
  wire [31:0] s_axi_wdata_in, s_axi_rdata_out, thresh_temporal_out,
              thresh_spatial_out, thresh_age_out;
  wire [3:0]  s_axi_wstrb_in;
  wire [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  wire        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in,
              s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in,
              s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out,
              s_axi_rready_in, vblank_out, hblank_out, active_video_out;
  pcc_ctrl_regs uut (.*);
  pcc_host host (.*);
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    #1 rnd = $random(seed);
    {hblank_in, active_video_in, video_data_in} = rnd[9:0];
  end
  // ------------------------------------------------------------
  // checks and model
  // ------------------------------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: %h, expected %h", $time, g, e);
      end
    end
  endtask
  function [1:0] rsp(input [7:0] a);
    rsp = (a == 0 || a == 8 || a == 12 || a == 16 || a == 20) ?
          `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
  endfunction
  task wreg(input [7:0] a, input [31:0] v);
    begin
      host.wr(a, v, r);
      chk(r, rsp(a));
      if (a == 8'h00) begin
        // the update bit only moves while the core is enabled or on the write that enables it
        ctl = (v[0] | ctl[0]) ? v[2:0] : {v[2], ctl[1], 1'b0};
        if (ctl[2] || !ctl[0]) sync = 1'b0;
        for (k = 0; k < 3; k = k + 1)
          if (ctl[2]) {sto[k], act[k]} = {rsv[k], rsv[k]};
      end else if (rsp(a) == 0 && a > 8 && !ctl[2])
        sto[(a - 8'd12) >> 2] = v;
    end
  endtask
  task rchk(input [7:0] a);
    begin
      host.rd(a, d, r);
      chk(r, rsp(a));
      case (a)
        8'h00: chk(d, ctl);
        8'h08: chk(d, {sync & ctl[0] & !ctl[2], 6'h00, sync});
        8'h0C, 8'h10, 8'h14: chk(d, sto[(a - 8'd12) >> 2]);
        default: chk(d, 0);
      endcase
    end
  endtask
  task thr;
    for (k = 0; k < 3; k = k + 1)
      chk(k == 0 ? thresh_temporal_out : k == 1 ? thresh_spatial_out :
          thresh_age_out, act[k]);
  endtask
  task vrise;
    begin
      vblank_in = 1'b1;
      if (ctl[0] && !ctl[2]) sync = 1'b1;
      for (k = 0; k < 3; k = k + 1)
        if (ctl == 3'h3) act[k] = sto[k];
      repeat (3) @(posedge clk_in);
      #1 vblank_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d, errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task hang;
    begin
      err_total = err_total + 1;
      give_verdict;
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rsv[0], rsv[1], rsv[2]} = {`PCC_TEMPORAL_RST, `PCC_SPATIAL_RST,
                                `PCC_AGE_RST};
    for (i = 0; i < 3; i = i + 1)
      {sto[i], act[i]} = {rsv[i], rsv[i]};
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    @(posedge clk_in) #1;
    thr;
    for (i = 0; i < 6; i = i + 1) rchk(4 * i);
    wreg(8'h08, 32'hFFFFFFFF);
    wreg(8'h04, 32'h00000005);
    wreg(8'h00, 32'h00000001);
    for (i = 0; i < 3; i = i + 1) wreg(12 + 4 * i, $random(seed));
    vrise;
    thr;
    for (i = 0; i < 4; i = i + 1) rchk(8 + 4 * i);
    wreg(8'h00, 32'h00000003);
    vrise;
    thr;
    wreg(8'h0C, $random(seed));
    vrise;
    thr;
    wreg(8'h00, 32'h00000001);
    wreg(8'h10, $random(seed));
    vrise;
    thr;
    wreg(8'h00, 32'h00000002);
    wreg(8'h0C, $random(seed));
    vrise;
    thr;
    wreg(8'h00, 32'h00000000);
    rchk(8'h00);
    wreg(8'h00, 32'h00000001);
    vrise;
    thr;
    wreg(8'h00, 32'h00000005);
    vblank_in = 1'b1;
    chk(video_data_out, 0);
    repeat (2) @(posedge clk_in);
    #1 chk({vblank_out, hblank_out, active_video_out,
            video_data_out}, 0);
    thr;
    rchk(8'h08);
    vblank_in = 1'b0;
    wreg(8'h00, 32'h00000001);
    chk(video_data_out, 0);
    vrise;
    @(posedge clk_in) #2 pix = {hblank_in, active_video_in, video_data_in};
    @(posedge clk_in) #2 chk({hblank_out, active_video_out,
                              video_data_out}, pix);
    rchk(8'h08);
    give_verdict;
  end
endmodule // test_pixel_correction_control_regs
